// file: hdl/tls_frame_pkg.sv
// Purpose: constants for the secure transmit request parser and command reply framer
// Assumes: frame bytes arrive without envelope; envelope length given as a port
// Notes on behaviour
// [RQ1] Type 0x23 means a secure transmit request; no protocol byte is needed.
// [RQ2] Layout: id, 32-bit address, two 16-bit ports, profile, options, all big endian.
// [RQ3] Frame identifier echoes in status reply; identifier zero suppresses that reply.
// [RQ4] Source port zero: reuse socket matching destination, else open a new one.
// [RQ5] Nonzero source port: exact socket match required, else error in status reply.
// [RQ6] Profile byte selects one of three profiles, numbered zero to two.
// [RQ7] Option bit 1 closes TCP socket after sending; otherwise timeout closes it.
// [RQ8] Host writes zero into option bits 0 and 2 through 7.
// [RQ9] Host keeps request payload at or below 1500 bytes.
// [RQ10] Each command request type 0x08 with a nonzero identifier gets reply frames of type 0x88.
// [RQ11] Command requests with identifier zero get no reply frame.
// [RQ12] Reply carries two command name characters after identifier, before status.
// [RQ13] Status: 0 ok, 1 error, 2 unknown command, 3 bad parameter.
// [RQ14] Parameter value follows status only for queries, never after a set.
// [RQ15] Transmit status reply: type 0x89, echoed identifier, one status byte, 0 ok.
// [RQ16] Payload length is envelope length minus fixed header bytes.
package tls_frame_pkg;
  localparam logic [7:0]  TYPE_TLS_REQ   = 8'h23;
  localparam logic [7:0]  TYPE_AT_REQ    = 8'h08;
  localparam logic [7:0]  TYPE_AT_RESP   = 8'h88;
  localparam logic [7:0]  TYPE_TX_STAT   = 8'h89;
  localparam logic [7:0]  ST_TX_OK       = 8'h00;
  localparam logic [7:0]  ST_CONN_NF     = 8'h20;
  localparam logic [7:0]  ST_BAD_CONFIG  = 8'h86;
  localparam logic [1:0]  AT_OK          = 2'h0;
  localparam logic [1:0]  AT_ERROR       = 2'h1;
  localparam logic [1:0]  AT_BAD_CMD     = 2'h2;
  localparam logic [1:0]  AT_BAD_PARAM   = 2'h3;
  localparam logic [7:0]  NUM_PROFILES   = 8'h03;
  localparam int          OPT_CLOSE_BIT  = 1;
  localparam logic [7:0]  OPT_RSVD_MASK  = 8'hfd;
  localparam logic [15:0] TLS_HDR_LEN    = 16'h000c;
  localparam logic [15:0] MAX_PAYLOAD    = 16'h05dc;
  localparam logic [3:0]  IDX_ID         = 4'h1;
  localparam logic [3:0]  IDX_ADDR_LAST  = 4'h5;
  localparam logic [3:0]  IDX_DPORT_LAST = 4'h7;
  localparam logic [3:0]  IDX_SPORT_LAST = 4'h9;
  localparam logic [3:0]  IDX_PROFILE    = 4'ha;
  localparam logic [3:0]  IDX_OPTIONS    = 4'hb;
  localparam logic [3:0]  IDX_PAYLOAD    = 4'hc;
  localparam int          FIFO_W         = 8;
  localparam int          FIFO_D         = 8;
endpackage : tls_frame_pkg

// file: hdl/byte_fifo.sv
// Purpose: small flop FIFO between request parser and socket data path
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact; push when full is refused by in_ready
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_t;
  fifo_t st_ff, nxt_st;
  logic push, pop;

  // Handshakes straight from the count
  assign in_ready  = (st_ff.cnt != (AW+1)'(D));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.mem[st_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer wrap relies on D being a power of two
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp            = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : byte_fifo

// file: hdl/tls_tx_framer.sv
// Purpose: parse secure transmit requests, emit transmit status and command replies
// Assumes: one request byte per IN_VALID beat, IN_LAST on final byte, IN_LEN from envelope
// Notes: socket table lives outside; this block looks up, opens and closes by ports
`timescale 1ns/1ps
module tls_tx_framer
  import tls_frame_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  IN_DATA,
  input  wire logic        IN_VALID,
  output logic             IN_READY,
  input  wire logic        IN_LAST,
  input  wire logic [15:0] IN_LEN,
  output logic [31:0]      DEST_ADDR,
  output logic [15:0]      DEST_PORT,
  output logic [15:0]      SRC_PORT,
  output logic [1:0]       PROFILE,
  output logic             CLOSE_AFTER,
  output logic [15:0]      PAYLOAD_LEN,
  output logic             LOOKUP_REQ,
  output logic             LOOKUP_ANY_SRC,
  input  wire logic        LOOKUP_DONE,
  input  wire logic        LOOKUP_HIT,
  output logic             OPEN_REQ,
  input  wire logic        OPEN_DONE,
  input  wire logic        OPEN_OK,
  output logic [7:0]       PAY_DATA,
  output logic             PAY_VALID,
  input  wire logic        PAY_READY,
  input  wire logic        SEND_DONE,
  input  wire logic        SEND_OK,
  input  wire logic        SOCK_IS_TCP,
  output logic             CLOSE_REQ,
  input  wire logic        AT_DONE,
  input  wire logic [7:0]  AT_ID,
  input  wire logic [15:0] AT_NAME,
  input  wire logic [1:0]  AT_STATUS,
  input  wire logic        AT_IS_QUERY,
  input  wire logic [7:0]  AT_VALUE,
  output logic             AT_BUSY,
  output logic [7:0]       OUT_DATA,
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  output logic             OUT_LAST,
  output logic             OPT_RSVD_ERR,
  output logic             LEN_ERR
);
  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_SKIP, S_CHECK, S_LOOK, S_OPEN, S_PAY, S_SEND, S_STAT, S_AT
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [3:0]  idx;
    logic [7:0]  ftype;
    logic [7:0]  fid;
    logic [31:0] addr;
    logic [15:0] dport;
    logic [15:0] sport;
    logic [7:0]  prof;
    logic [7:0]  opts;
    logic [15:0] plen;
    logic [15:0] pcnt;
    logic        sent;
    logic [7:0]  status;
    logic [5:0][7:0] obuf;
    logic [2:0]  olen;
    logic [2:0]  optr;
    logic        rsvd_err;
    logic        len_err;
  } frm_t;

  frm_t st_ff, nxt_st;
  logic       fifo_in_ready;
  logic       fifo_push;
  logic       in_take;

  // Output frame builder for transmit status replies; command replies are built in idle
  function automatic logic [5:0][7:0] pack_stat(input logic [7:0] id, input logic [7:0] s);
    logic [5:0][7:0] b;
    b    = '0;
    b[0] = TYPE_TX_STAT; // [RQ15]
    b[1] = id;           // [RQ3]
    b[2] = s;
    return b;
  endfunction : pack_stat

  // Big-endian shift-in, reused for address and ports
  function automatic logic [31:0] shift_in(input logic [31:0] v, input logic [7:0] d);
    return {v[23:0], d};
  endfunction : shift_in

  // Handshakes decode from state; payload stalls on the FIFO
  assign in_take   = IN_VALID && IN_READY;
  assign fifo_push = (st_ff.st == S_PAY) && IN_VALID && fifo_in_ready;
  // A command reply starting in idle wins, so a request byte is not acked and then lost
  assign IN_READY  = ((st_ff.st == S_IDLE) && !(AT_DONE && (AT_ID != '0)))
                   || (st_ff.st == S_HDR) || (st_ff.st == S_SKIP)
                   || ((st_ff.st == S_PAY) && fifo_in_ready);
  assign AT_BUSY   = (st_ff.st != S_IDLE);
  assign OUT_DATA  = st_ff.obuf[st_ff.optr];
  // Identifier zero passes through the status state without showing a byte
  assign OUT_VALID = ((st_ff.st == S_STAT) && (st_ff.fid != '0)) // [RQ3]
                   || (st_ff.st == S_AT);
  assign OUT_LAST  = OUT_VALID && (st_ff.optr == st_ff.olen - 3'h1);
  assign LOOKUP_REQ     = (st_ff.st == S_LOOK);
  assign LOOKUP_ANY_SRC = (st_ff.sport == '0); // [RQ4]
  assign OPEN_REQ       = (st_ff.st == S_OPEN);
  assign CLOSE_REQ      = (st_ff.st == S_SEND) && SEND_DONE && SEND_OK && SOCK_IS_TCP
                        && st_ff.opts[OPT_CLOSE_BIT]; // [RQ7]
  assign DEST_ADDR      = st_ff.addr;
  assign DEST_PORT      = st_ff.dport;
  assign SRC_PORT       = st_ff.sport;
  assign PROFILE        = st_ff.prof[1:0]; // [RQ6]
  assign CLOSE_AFTER    = st_ff.opts[OPT_CLOSE_BIT];
  assign PAYLOAD_LEN    = st_ff.plen;
  assign OPT_RSVD_ERR   = st_ff.rsvd_err;
  assign LEN_ERR        = st_ff.len_err;

  // Main sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.st)
      S_IDLE: begin
        // A finished command reply waits here; requests are held off meanwhile
        if (AT_DONE && (AT_ID != '0)) begin // [RQ11]
          nxt_st.obuf    = '0;
          nxt_st.obuf[0] = TYPE_AT_RESP;      // [RQ10]
          nxt_st.obuf[1] = AT_ID;
          nxt_st.obuf[2] = AT_NAME[15:8];     // [RQ12]
          nxt_st.obuf[3] = AT_NAME[7:0];
          nxt_st.obuf[4] = {6'h00, AT_STATUS}; // [RQ13]
          nxt_st.obuf[5] = AT_VALUE;
          nxt_st.olen    = (AT_IS_QUERY && AT_STATUS == AT_OK) ? 3'h6 : 3'h5; // [RQ14]
          nxt_st.optr    = '0;
          nxt_st.st      = S_AT;
        end else if (in_take) begin
          nxt_st.ftype = IN_DATA;
          nxt_st.idx   = IDX_ID;
          nxt_st.sent  = 1'b0;
          // Only type 0x23 is handled; others are drained to the last byte
          nxt_st.st    = (IN_DATA == TYPE_TLS_REQ) ? S_HDR : S_SKIP; // [RQ1]
          if (IN_LAST) begin
            nxt_st.st = S_IDLE;
          end
        end
      end
      S_HDR: begin
        if (in_take) begin
          // Fixed header order, big endian fields [RQ2]
          if (st_ff.idx == IDX_ID) begin
            nxt_st.fid = IN_DATA;
          end else if (st_ff.idx <= IDX_ADDR_LAST) begin
            nxt_st.addr = shift_in(st_ff.addr, IN_DATA);
          end else if (st_ff.idx <= IDX_DPORT_LAST) begin
            nxt_st.dport = 16'(shift_in({16'h0000, st_ff.dport}, IN_DATA));
          end else if (st_ff.idx <= IDX_SPORT_LAST) begin
            nxt_st.sport = 16'(shift_in({16'h0000, st_ff.sport}, IN_DATA));
          end else if (st_ff.idx == IDX_PROFILE) begin
            nxt_st.prof = IN_DATA;
          end else begin
            nxt_st.opts = IN_DATA;
          end
          nxt_st.idx = st_ff.idx + 4'h1;
          if (st_ff.idx == IDX_OPTIONS) begin
            nxt_st.plen = IN_LEN - TLS_HDR_LEN; // [RQ16]
            nxt_st.pcnt = '0;
            nxt_st.st   = S_CHECK;
          end
          if (IN_LAST && st_ff.idx != IDX_OPTIONS) begin
            nxt_st.st = S_IDLE; // Truncated header dropped
          end
        end
      end
      S_SKIP: begin
        if (in_take && IN_LAST) begin
          nxt_st.st = S_IDLE;
        end
      end
      S_CHECK: begin
        // Host-side duties flagged, not enforced
        nxt_st.rsvd_err = |(st_ff.opts & OPT_RSVD_MASK); // [RQ8]
        nxt_st.len_err  = (st_ff.plen > MAX_PAYLOAD);     // [RQ9]
        if (st_ff.prof >= NUM_PROFILES) begin
          nxt_st.status = ST_BAD_CONFIG; // [RQ6]
          nxt_st.st     = S_PAY;
          nxt_st.sent   = 1'b1;          // Payload drained, not sent
        end else begin
          nxt_st.st = S_LOOK;
        end
      end
      S_LOOK: begin
        if (LOOKUP_DONE) begin
          if (LOOKUP_HIT) begin
            nxt_st.st = S_PAY;
          end else if (st_ff.sport == '0) begin
            nxt_st.st = S_OPEN; // [RQ4]
          end else begin
            nxt_st.status = ST_CONN_NF; // [RQ5]
            nxt_st.sent   = 1'b1;
            nxt_st.st     = S_PAY;
          end
        end
      end
      S_OPEN: begin
        if (OPEN_DONE) begin
          nxt_st.st = S_PAY; // [RQ4]
          if (!OPEN_OK) begin
            nxt_st.status = ST_CONN_NF;
            nxt_st.sent   = 1'b1;
          end
        end
      end
      S_PAY: begin
        // On an error path sent is set and bytes are discarded
        if (in_take) begin
          nxt_st.pcnt = st_ff.pcnt + 16'h0001;
          if (IN_LAST) begin
            nxt_st.st = st_ff.sent ? S_STAT : S_SEND;
          end
        end else if (st_ff.plen == '0) begin
          nxt_st.st = st_ff.sent ? S_STAT : S_SEND;
        end
        nxt_st.obuf = pack_stat(st_ff.fid, st_ff.status);
        nxt_st.olen = 3'h3;
        nxt_st.optr = '0;
      end
      S_SEND: begin
        if (SEND_DONE) begin
          nxt_st.status = SEND_OK ? ST_TX_OK : ST_CONN_NF; // [RQ15]
          nxt_st.obuf   = pack_stat(st_ff.fid, SEND_OK ? ST_TX_OK : ST_CONN_NF);
          nxt_st.st     = S_STAT;
        end
      end
      S_STAT: begin
        if (st_ff.fid == '0) begin
          nxt_st.st = S_IDLE; // [RQ3]
        end else if (OUT_READY) begin
          nxt_st.optr = st_ff.optr + 3'h1;
          if (OUT_LAST) begin
            nxt_st.st     = S_IDLE;
            nxt_st.status = ST_TX_OK;
          end
        end
      end
      S_AT: begin
        if (OUT_READY) begin
          nxt_st.optr = st_ff.optr + 3'h1;
          if (OUT_LAST) begin
            nxt_st.st = S_IDLE;
          end
        end
      end
      default: begin
        nxt_st.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Payload buffer; its ready stalls the request stream
  byte_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_pay_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_data   (IN_DATA),
    .in_valid  (fifo_push && !st_ff.sent),
    .in_ready  (fifo_in_ready),
    .out_data  (PAY_DATA),
    .out_valid (PAY_VALID),
    .out_ready (PAY_READY)
  );
endmodule : tls_tx_framer

// file: verif/tls_tx_framer_props.sv
// Purpose: port-level checks on the secure request parser and reply framer
// Assumes: one clock; reset low disables every check
// Notes: a byte counter tracks position inside each reply frame
`timescale 1ns/1ps
module tls_tx_framer_props (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        IN_READY,
  input wire logic [15:0] SRC_PORT,
  input wire logic        LOOKUP_REQ,
  input wire logic        LOOKUP_ANY_SRC,
  input wire logic        LOOKUP_DONE,
  input wire logic        SEND_DONE,
  input wire logic        SEND_OK,
  input wire logic        SOCK_IS_TCP,
  input wire logic        CLOSE_AFTER,
  input wire logic        CLOSE_REQ,
  input wire logic        AT_DONE,
  input wire logic [7:0]  AT_ID,
  input wire logic        AT_BUSY,
  input wire logic [7:0]  OUT_DATA,
  input wire logic        OUT_VALID,
  input wire logic        OUT_READY,
  input wire logic        OUT_LAST
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic [2:0] cnt_ff;
  logic [7:0] first_ff;
  // Byte position in the reply and its type byte; short frames only, so 3 bits do
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_ff   <= 3'h0;
      first_ff <= 8'h00;
    end else if (OUT_VALID && OUT_READY) begin
      cnt_ff <= OUT_LAST ? 3'h0 : cnt_ff + 3'h1;
      if (cnt_ff == 3'h0) first_ff <= OUT_DATA;
    end
  end
  AST_FIRST_TYPE: assert property (
    OUT_VALID && cnt_ff == 3'h0 |-> OUT_DATA inside {8'h88, 8'h89})
    else $error("reply starts with a wrong type byte");
  AST_TX_LEN: assert property (
    OUT_VALID && OUT_LAST && cnt_ff != 3'h0 && first_ff == 8'h89 |-> cnt_ff == 3'h2)
    else $error("transmit status reply is not three bytes");
  AST_AT_LEN: assert property (
    OUT_VALID && OUT_LAST && cnt_ff != 3'h0 && first_ff == 8'h88 |-> cnt_ff inside {3'h4, 3'h5})
    else $error("command reply has a wrong length");
  AST_AT_START: assert property (
    AT_DONE && !AT_BUSY && AT_ID != 8'h00 |=> OUT_VALID && OUT_DATA == 8'h88)
    else $error("command reply did not start next cycle");
  AST_AT_QUIET: assert property (
    AT_DONE && !AT_BUSY && AT_ID == 8'h00 |=> !OUT_VALID [*2])
    else $error("reply sent for identifier zero");
  AST_CLOSE: assert property (
    CLOSE_REQ |-> SEND_DONE && SEND_OK && SOCK_IS_TCP && CLOSE_AFTER)
    else $error("close request without a finished tcp send");
  AST_ANY_SRC: assert property (
    LOOKUP_REQ |-> LOOKUP_ANY_SRC == (SRC_PORT == 16'h0000))
    else $error("lookup match mode does not follow source port");
  AST_LOOK_HOLD: assert property (
    LOOKUP_REQ && !LOOKUP_DONE |-> !IN_READY ##1 LOOKUP_REQ)
    else $error("lookup dropped early or input open during lookup");
  AST_OUT_HOLD: assert property (
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST))
    else $error("reply byte changed while stalled");
  COV_QUERY: cover property (OUT_VALID && OUT_READY && OUT_LAST && first_ff == 8'h88 && cnt_ff == 3'h5);
  COV_STATUS: cover property (OUT_VALID && OUT_READY && OUT_LAST && first_ff == 8'h89);
  COV_CLOSE: cover property (CLOSE_REQ);
endmodule : tls_tx_framer_props
bind tls_tx_framer tls_tx_framer_props tls_tx_framer_props_i (.*);

// file: verif/sock_model.sv
// Purpose: behavioural socket side answering lookups, opens and sends
// Assumes: bench sets hit, open result and transport before each request
// Notes: answers alternate fast and slow; payload side stalls one beat in four
`timescale 1ns/1ps
module sock_model (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        cfg_hit,
  input  wire logic        cfg_ok,
  input  wire logic        cfg_tcp,
  input  wire logic        LOOKUP_REQ,
  input  wire logic        OPEN_REQ,
  input  wire logic        PAY_VALID,
  input  wire logic [15:0] PAYLOAD_LEN,
  output logic             LOOKUP_DONE,
  output logic             LOOKUP_HIT,
  output logic             OPEN_DONE,
  output logic             OPEN_OK,
  output logic             PAY_READY,
  output logic             SEND_DONE,
  output logic             SEND_OK,
  output logic             SOCK_IS_TCP
);
  logic [2:0]  wait_ff;
  logic [15:0] cnt_ff, tick_ff;
  logic        slow_ff, armed_ff;
  // Qualifiers toggle outside their pulse so a stale value never passes
  always_ff @(posedge CLK) begin
    {LOOKUP_DONE, OPEN_DONE, SEND_DONE} <= 3'h0;
    if (!RST_N) begin
      {LOOKUP_HIT, OPEN_OK, SEND_OK, SOCK_IS_TCP, PAY_READY} <= 5'h00;
      {wait_ff, cnt_ff, tick_ff, slow_ff, armed_ff} <= '0;
    end else begin
      tick_ff <= tick_ff + 16'h1;
      PAY_READY <= tick_ff[1:0] != 2'h3;
      {LOOKUP_HIT, OPEN_OK, SEND_OK, SOCK_IS_TCP} <= ~{LOOKUP_HIT, OPEN_OK, SEND_OK, SOCK_IS_TCP};
      if ((LOOKUP_REQ || OPEN_REQ) && !LOOKUP_DONE && !OPEN_DONE) begin
        wait_ff <= wait_ff + 3'h1;
        if (wait_ff == (slow_ff ? 3'h5 : 3'h1)) begin
          wait_ff <= 3'h0;
          slow_ff <= ~slow_ff;
          LOOKUP_DONE <= LOOKUP_REQ;
          LOOKUP_HIT <= cfg_hit;
          OPEN_DONE <= !LOOKUP_REQ;
          OPEN_OK <= cfg_ok;
          armed_ff <= LOOKUP_REQ ? cfg_hit : cfg_ok;
          cnt_ff <= 16'h0;
        end
      end
      if (armed_ff && PAY_VALID && PAY_READY) cnt_ff <= cnt_ff + 16'h1;
      // Send ends once every payload byte has left; transport reported with it
      if (armed_ff && cnt_ff == PAYLOAD_LEN && !LOOKUP_DONE && !OPEN_DONE) begin
        armed_ff <= 1'b0;
        SEND_DONE <= 1'b1;
        SEND_OK <= 1'b1;
        SOCK_IS_TCP <= cfg_tcp;
      end
    end
  end
endmodule : sock_model

// file: verif/tls_tx_framer_bench.sv
// Purpose: self-checking bench for secure requests and command replies
// Assumes: socket side played by sock_model; reply side stalls at random
// Notes: all random values come from two fixed-seed shift registers, rnd and rdy
`timescale 1ns/1ps
module tls_tx_framer_bench;
  import tls_frame_pkg::*;
  logic        CLK = 0, RST_N = 0, IN_VALID = 0, IN_LAST = 0, AT_DONE = 0, AT_IS_QUERY = 0;
  logic        OUT_READY = 0, cfg_hit = 0, cfg_ok = 0, cfg_tcp = 0;
  logic [7:0]  IN_DATA = 0, AT_ID = 0, AT_VALUE = 0, PAY_DATA, OUT_DATA;
  logic [15:0] IN_LEN = 0, AT_NAME = 0, DEST_PORT, SRC_PORT, PAYLOAD_LEN;
  logic [1:0]  AT_STATUS = 0, PROFILE;
  logic [31:0] DEST_ADDR;
  logic        IN_READY, CLOSE_AFTER, LOOKUP_REQ, LOOKUP_ANY_SRC, LOOKUP_DONE, LOOKUP_HIT;
  logic        OPEN_REQ, OPEN_DONE, OPEN_OK, PAY_VALID, PAY_READY, SEND_DONE, SEND_OK;
  logic        SOCK_IS_TCP, CLOSE_REQ, AT_BUSY, OUT_VALID, OUT_LAST, OPT_RSVD_ERR, LEN_ERR;
  logic [15:0] rnd = 16'h0034, rdy = 16'h0034;
  logic [7:0]  out_q[$], pay_q[$], exp_q[$], exp_p[$];
  int          err_count = 0, check_count = 0, close_n = 0;
  tls_tx_framer tls_tx_framer_i (.*);
  sock_model sock_model_i (.*);
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // Status the socket side should lead to, from profile, source port and socket state
  function automatic logic [7:0] exp_stat(input logic [7:0] prof, input logic [15:0] sp);
    if (prof > 8'h02) return ST_BAD_CONFIG;
    if (!cfg_hit && (sp != 16'h0000 || !cfg_ok)) return ST_CONN_NF;
    return ST_TX_OK;
  endfunction : exp_stat
  // Capture both output streams; reply side stalls at random
  always @(posedge CLK) begin
    if (OUT_VALID && OUT_READY) out_q.push_back(OUT_DATA);
    if (PAY_VALID && PAY_READY) pay_q.push_back(PAY_DATA);
    if (CLOSE_REQ) close_n++;
    rdy = lfsr(rdy);
    OUT_READY <= rdy[0] | rdy[2];
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Bounded wait for input ready, or for the block to fall idle
  task automatic wait_for(input bit idle);
    int k;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (!(idle ? (AT_BUSY === 1'b0 && OUT_VALID === 1'b0) : IN_READY === 1'b1) && k < 9000);
    if (k >= 9000) begin
      err_count++;
      end_sim;
    end
  endtask : wait_for
  task automatic cmp_out;
    chk("reply length", out_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < out_q.size()) chk("reply byte", out_q[i], exp_q[i]);
    out_q = {};
    exp_q = {};
  endtask : cmp_out
  task automatic at_reply(input logic [7:0] id, input logic [1:0] st, input logic q);
    rnd = lfsr(rnd);
    AT_DONE <= 1'b1;
    AT_ID <= id;
    AT_NAME <= rnd;
    AT_STATUS <= st;
    AT_IS_QUERY <= q;
    AT_VALUE <= rnd[7:0] ^ 8'h3c;
    @(posedge CLK);
    AT_DONE <= 1'b0;
    AT_ID <= ~id;
    wait_for(1);
    if (id != 8'h00) exp_q = {TYPE_AT_RESP, id, rnd[15:8], rnd[7:0], 8'(st)};
    if (id != 8'h00 && q && st == AT_OK) exp_q.push_back(rnd[7:0] ^ 8'h3c);
    cmp_out;
  endtask : at_reply
  task automatic send_frame(input logic [7:0] typ, fid, prof, opt, input logic [15:0] sp,
                            input int n);
    logic [7:0]  b[$];
    logic [31:0] da;
    logic [15:0] dp;
    logic [7:0]  st;
    rnd = lfsr(rnd);
    da = {rnd, ~rnd};
    dp = rnd ^ 16'h1234;
    b = {typ, fid, da[31:24], da[23:16], da[15:8], da[7:0], dp[15:8], dp[7:0], sp[15:8], sp[7:0],
         prof, opt};
    repeat (n) begin
      rnd = lfsr(rnd);
      b.push_back(rnd[7:0]);
      exp_p.push_back(rnd[7:0]);
    end
    IN_LEN <= 16'(b.size()); // Envelope counts every frame byte, type included
    foreach (b[i]) begin
      IN_DATA <= b[i];
      IN_VALID <= 1'b1;
      IN_LAST <= (i == b.size() - 1);
      wait_for(0);
    end
    IN_VALID <= 1'b0;
    IN_LAST <= 1'b0;
    wait_for(1);
    st = exp_stat(prof, sp);
    if (typ == TYPE_TLS_REQ) begin
      chk("dest addr", DEST_ADDR, da);
      chk("dest port", DEST_PORT, dp);
      chk("src port", SRC_PORT, sp);
      chk("payload len", PAYLOAD_LEN, n);
      chk("close flag", CLOSE_AFTER, opt[1]);
      chk("rsvd flag", OPT_RSVD_ERR, |(opt & OPT_RSVD_MASK));
      chk("len flag", LEN_ERR, n > 1500);
      if (prof < 8'h03) chk("profile", PROFILE, prof);
      if (fid != 8'h00) exp_q = {TYPE_TX_STAT, fid, st};
      chk("close count", close_n, st == ST_TX_OK && cfg_tcp && opt[1]);
      if (st == ST_TX_OK) begin
        chk("payload count", pay_q.size(), exp_p.size());
        foreach (exp_p[i]) if (i < pay_q.size()) chk("payload", pay_q[i], exp_p[i]);
      end
    end
    cmp_out;
    pay_q = {};
    exp_p = {};
    close_n = 0;
  endtask : send_frame
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    // Every status with and without query, then a silent identifier
    for (int s = 0; s < 8; s++) at_reply(8'h11 + 8'(s), 2'(s), s[2]);
    at_reply(8'h00, AT_OK, 1'b1);
    // Oversize payload fills the buffer, then silent id, then a foreign frame type
    {cfg_hit, cfg_ok, cfg_tcp} <= 3'h7;
    send_frame(TYPE_TLS_REQ, 8'h42, 8'h00, 8'h83, 16'h0000, 1501);
    send_frame(TYPE_TLS_REQ, 8'h00, 8'h02, 8'h02, 16'h0101, 0);
    send_frame(TYPE_AT_REQ, 8'h05, 8'h00, 8'h00, 16'h0000, 2);
    // Random requests; host keeps reserved option bits clear
    repeat (14) begin
      rnd = lfsr(rnd);
      {cfg_hit, cfg_ok, cfg_tcp} <= rnd[7:5];
      send_frame(TYPE_TLS_REQ, {rnd[3:0], rnd[15:12]}, {6'h00, rnd[1:0]}, {6'h00, rnd[8], 1'b0},
                 rnd[4] ? rnd : 16'h0000, int'(rnd[11:9]));
    end
    end_sim;
  end
endmodule : tls_tx_framer_bench
